// file: core/plc_link_address_config.sv
// controller link address configuration register bank
// Summary of operation
// RQ1: register class selects data, file, link or extended file registers; 4-29 unused.
// RQ2: base high part holds 0 to 15, used only beyond 65535.
// RQ3: base low part holds 0 to 65535, factory value 1000.
// RQ4: configurer splits extended bases 65536 to 1042431 into high and low parts.
// RQ5: select 0 adds switch value times bias to base; select 1 applies none.
// RQ6: bias is 16-bit unsigned, factory value 0.
// RQ7: new settings take effect only after reset or stop-to-run change; here reset reloads factory values and the address switch acts live.
// RQ8: status block is 8 consecutive words starting at effective base.
// RQ9: all settings readable and writable with no channel selection.
// RQ10: liveness word toggles 0/1 or counts per cycle, wrapping at 30000.
// RQ11: high part carries base bits 19:16, low part bits 15:0.
`timescale 1ns/1ns
module plc_link_address_config
    import plc_link_pkg::*;
(
    input  wire logic                clock_i,
    input  wire logic                rstn_i,
    input  wire logic [15:0]         reg_addr_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    input  wire logic [15:0]         reg_wdata_i,
    output logic [15:0]              reg_rdata_o,
    output logic                     reg_ack_o,
    output logic                     reg_err_o,
    input  wire logic                run_i,
    input  wire logic [switch_w-1:0] addr_switch_i,
    input  wire logic                live_mode_i,
    input  wire logic                comm_cycle_i,
    input  wire logic [eff_w-1:0]    plc_addr_i,
    output logic [eff_w-1:0]         eff_base_o,
    output logic [15:0]              active_class_o,
    output logic                     status_hit_o,
    output logic [2:0]               status_index_o,
    output logic [15:0]              live_word_o
);

    typedef struct packed {
        cfg_s            shadow;
        cfg_s            active;
        logic            run_q;
        logic [15:0]     rdata;
        logic            ack;
        logic            err;
        eff_addr_t       eff_base;
        logic            hit;
        logic [2:0]      index;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    // ========================================================
    // helpers
    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lim);
        in_range = (v <= lim);
    endfunction : in_range

    function automatic eff_addr_t calc_base(input cfg_s c, input logic [switch_w-1:0] sw);
        eff_addr_t base;
        eff_addr_t offs;
        base = eff_addr_t'({c.base_high[3:0], c.base_low}); // RQ11
        offs = eff_addr_t'(sw) * eff_addr_t'(c.bias);
        if (c.bias_sel == sel_bias_enabled)
            calc_base = base + offs; // RQ5
        else
            calc_base = base; // RQ5
    endfunction : calc_base

    eff_addr_t rel_addr;
    assign rel_addr = plc_addr_i - st_ff.eff_base;

    // ========================================================
    // next state
    always_comb
    begin
        nxt_st       = st_ff;
        nxt_st.run_q = run_i;
        nxt_st.ack   = reg_wr_i | reg_rd_i;
        nxt_st.err   = 1'b0;
        // reads are channel-free; unmapped reads give zero and flag an error
        if (reg_rd_i)
        begin
            unique case (reg_addr_i) // RQ9
                ofs_plc_register_class: nxt_st.rdata = st_ff.shadow.reg_class;
                ofs_base_number_high:   nxt_st.rdata = st_ff.shadow.base_high;
                ofs_base_number_low:    nxt_st.rdata = st_ff.shadow.base_low;
                ofs_unit_address_bias:  nxt_st.rdata = st_ff.shadow.bias;
                ofs_bias_apply_select:  nxt_st.rdata = st_ff.shadow.bias_sel;
                default:
                begin
                    nxt_st.rdata = 16'h0000;
                    nxt_st.err   = 1'b1;
                end
            endcase
        end
        // out-of-range writes are refused and leave the value untouched
        if (reg_wr_i)
        begin
            unique case (reg_addr_i) // RQ9
                ofs_plc_register_class:
                    if (in_range(reg_wdata_i, max_plc_register_class))
                        nxt_st.shadow.reg_class = reg_wdata_i; // RQ1
                    else
                        nxt_st.err = 1'b1; // RQ1
                ofs_base_number_high:
                    if (in_range(reg_wdata_i, max_base_number_high))
                        nxt_st.shadow.base_high = reg_wdata_i; // RQ2
                    else
                        nxt_st.err = 1'b1; // RQ2
                ofs_base_number_low:   nxt_st.shadow.base_low = reg_wdata_i; // RQ3
                ofs_unit_address_bias: nxt_st.shadow.bias = reg_wdata_i; // RQ6
                ofs_bias_apply_select:
                    if (in_range(reg_wdata_i, max_bias_apply_select))
                        nxt_st.shadow.bias_sel = reg_wdata_i; // RQ5
                    else
                        nxt_st.err = 1'b1; // RQ5
                default: nxt_st.err = 1'b1;
            endcase
        end
        // the running link never sees half-updated settings
        if (run_i && !st_ff.run_q)
            nxt_st.active = st_ff.shadow; // RQ7
        nxt_st.eff_base = calc_base(st_ff.active, addr_switch_i); // RQ5
        nxt_st.hit      = (plc_addr_i >= st_ff.eff_base) &&
                          (rel_addr < eff_addr_t'(status_words)); // RQ8
        nxt_st.index    = rel_addr[2:0]; // RQ8
    end

    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            st_ff          <= '0;
            st_ff.shadow   <= cfg_reset; // RQ3
            st_ff.active   <= cfg_reset; // RQ7
            st_ff.run_q    <= 1'b1;
            st_ff.eff_base <= eff_addr_t'({rst_base_number_high[3:0], rst_base_number_low});
        end
        else
            st_ff <= nxt_st;
    end

    assign reg_rdata_o    = st_ff.rdata;
    assign reg_ack_o      = st_ff.ack;
    assign reg_err_o      = st_ff.err;
    assign eff_base_o     = st_ff.eff_base;
    assign active_class_o = st_ff.active.reg_class;
    assign status_hit_o   = st_ff.hit;
    assign status_index_o = st_ff.index;

    live_counter u_live
    (
        .clock_i      (clock_i),
        .rstn_i       (rstn_i),
        .count_mode_i (live_mode_i),
        .cycle_i      (comm_cycle_i),
        .live_word_o  (live_word_o)
    );

    // ========================================================
    // checks
    property p_class_range;
        @(posedge clock_i) disable iff (!rstn_i)
        (reg_wr_i && reg_addr_i == ofs_plc_register_class && reg_wdata_i > max_plc_register_class)
        |=> reg_err_o && $stable(st_ff.shadow.reg_class);
    endproperty
    a_class_range: assert property (p_class_range) else $error("bad class taken"); // RQ1

    property p_high_range;
        @(posedge clock_i) disable iff (!rstn_i)
        st_ff.shadow.base_high <= max_base_number_high;
    endproperty
    a_high_range: assert property (p_high_range) else $error("high part over 15"); // RQ2

    property p_low_write;
        @(posedge clock_i) disable iff (!rstn_i)
        (reg_wr_i && reg_addr_i == ofs_base_number_low)
        |=> st_ff.shadow.base_low == $past(reg_wdata_i);
    endproperty
    a_low_write: assert property (p_low_write) else $error("low part not stored"); // RQ3

    property p_bias_off;
        @(posedge clock_i) disable iff (!rstn_i)
        (st_ff.active.bias_sel != sel_bias_enabled)
        |=> eff_base_o == eff_addr_t'({$past(st_ff.active.base_high[3:0]),
                                      $past(st_ff.active.base_low)});
    endproperty
    a_bias_off: assert property (p_bias_off) else $error("bias applied when off"); // RQ5

    property p_active_hold;
        @(posedge clock_i) disable iff (!rstn_i)
        !(run_i && !st_ff.run_q) |=> $stable(st_ff.active);
    endproperty
    a_active_hold: assert property (p_active_hold) else $error("settings changed early"); // RQ7

    property p_window;
        @(posedge clock_i) disable iff (!rstn_i)
        (plc_addr_i == st_ff.eff_base + eff_addr_t'(status_words)) |=> !status_hit_o;
    endproperty
    a_window: assert property (p_window) else $error("window longer than 8"); // RQ8

    property p_readback;
        @(posedge clock_i) disable iff (!rstn_i)
        (reg_wr_i && reg_addr_i == ofs_unit_address_bias) ##1
        (reg_rd_i && reg_addr_i == ofs_unit_address_bias && !reg_wr_i)
        |=> reg_rdata_o == $past(reg_wdata_i, 2) && reg_ack_o;
    endproperty
    a_readback: assert property (p_readback) else $error("bias read back wrong"); // RQ9

    property p_ack_pulse;
        @(posedge clock_i) disable iff (!rstn_i)
        (reg_wr_i || reg_rd_i) |=> reg_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("strobe not acknowledged"); // RQ9

    // the whole shadow moves at once, so a half-written base never reaches the link
    property p_run_load;
        @(posedge clock_i) disable iff (!rstn_i)
        (run_i && !st_ff.run_q) |=> st_ff.active == $past(st_ff.shadow);
    endproperty
    a_run_load: assert property (p_run_load) else $error("settings not loaded on run"); // RQ7

endmodule : plc_link_address_config

// file: core/plc_link_pkg.sv
// constants and types for the controller link address configuration bank
package plc_link_pkg;

    // ========================================================
    // register offsets (documented register addresses)
    localparam logic [15:0] ofs_plc_register_class = 16'h800A;
    localparam logic [15:0] ofs_base_number_high   = 16'h800B;
    localparam logic [15:0] ofs_base_number_low    = 16'h800C;
    localparam logic [15:0] ofs_unit_address_bias  = 16'h800D;
    localparam logic [15:0] ofs_bias_apply_select  = 16'h8012;

    // ========================================================
    // reset values and legal ranges
    localparam logic [15:0] rst_plc_register_class = 16'h0000;
    localparam logic [15:0] rst_base_number_high   = 16'h0000;
    localparam logic [15:0] rst_base_number_low    = 16'h03E8;
    localparam logic [15:0] rst_unit_address_bias  = 16'h0000;
    localparam logic [15:0] rst_bias_apply_select  = 16'h0001;
    localparam logic [15:0] max_plc_register_class = 16'h001D;
    localparam logic [15:0] max_base_number_high   = 16'h000F;
    localparam logic [15:0] max_bias_apply_select  = 16'h0001;
    localparam logic [15:0] sel_bias_enabled       = 16'h0000;

    // register classes
    localparam logic [15:0] cls_data_register          = 16'h0000;
    localparam logic [15:0] cls_file_register          = 16'h0001;
    localparam logic [15:0] cls_link_register          = 16'h0002;
    localparam logic [15:0] cls_extended_file_register = 16'h0003;

    // ========================================================
    // window and liveness
    localparam int          base_w          = 20;
    localparam int          switch_w        = 8;
    localparam int          eff_w           = 25;
    localparam logic [3:0]  status_words    = 4'h8;
    localparam logic [15:0] live_count_wrap = 16'h7530;
    localparam logic [15:0] live_one        = 16'h0001;

    typedef logic [eff_w-1:0] eff_addr_t;

    typedef struct packed {
        logic [15:0] reg_class;
        logic [15:0] base_high;
        logic [15:0] base_low;
        logic [15:0] bias;
        logic [15:0] bias_sel;
    } cfg_s;

    localparam cfg_s cfg_reset = '{rst_plc_register_class, rst_base_number_high,
                                   rst_base_number_low, rst_unit_address_bias,
                                   rst_bias_apply_select};

endpackage : plc_link_pkg

// file: core/live_counter.sv
// liveness status word generator
`timescale 1ns/1ns
module live_counter
    import plc_link_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic        count_mode_i,
    input  wire logic        cycle_i,
    output logic [15:0]      live_word_o
);

    typedef struct packed {
        logic [15:0] word;
    } live_s;

    live_s st_ff;
    live_s nxt_st;

    // ========================================================
    // next state
    always_comb
    begin
        nxt_st = st_ff;
        if (cycle_i)
        begin
            if (!count_mode_i)
                nxt_st.word = (st_ff.word == 16'h0000) ? live_one : 16'h0000; // RQ10
            else if (st_ff.word >= live_count_wrap)
                nxt_st.word = 16'h0000; // RQ10
            else
                nxt_st.word = st_ff.word + live_one; // RQ10
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign live_word_o = st_ff.word;

    // ========================================================
    // checks
    property p_live_wrap;
        @(posedge clock_i) disable iff (!rstn_i)
        (cycle_i && count_mode_i && live_word_o == live_count_wrap) |=> live_word_o == 16'h0000;
    endproperty
    a_live_wrap: assert property (p_live_wrap) else $error("count did not wrap"); // RQ10

    property p_live_hold;
        @(posedge clock_i) disable iff (!rstn_i)
        !cycle_i |=> $stable(live_word_o);
    endproperty
    a_live_hold: assert property (p_live_hold) else $error("word moved without cycle"); // RQ10

endmodule : live_counter

// file: testbench/plc_model.sv
// controller-side model: drives accessed register numbers and cycle pulses
`timescale 1ns/1ns
module plc_model
    import plc_link_pkg::*;
(
    input  wire logic        clock_i,
    output logic [eff_w-1:0] plc_addr_o,
    output logic             cycle_o
);
    // ========================================================
    // access and cycle tasks, both change lines at the falling edge
    initial plc_addr_o = '0;
    initial cycle_o = 1'b0;
    task automatic access(input logic [eff_w-1:0] a);
        @(negedge clock_i);
        plc_addr_o = a;
    endtask : access
    // back-to-back pulses: the hardest rate the far side can produce
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(negedge clock_i);
            cycle_o = 1'b1;
        end
        @(negedge clock_i);
        cycle_o = 1'b0;
    endtask : pulse
endmodule : plc_model

// file: testbench/tb_top.sv
// self-checking bench for the controller link address configuration bank
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    import plc_link_pkg::*;
    // ========================================================
    // stimulus and wiring
    logic clock_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, run_i = 1, live_mode_i = 0;
    logic [15:0] reg_addr_i = 16'h0000, reg_wdata_i = 16'h0000;
    logic [switch_w-1:0] addr_switch_i = '0;
    logic [15:0] reg_rdata_o, active_class_o, live_word_o;
    logic reg_ack_o, reg_err_o, status_hit_o, comm_cycle_i;
    logic [2:0] status_index_o;
    logic [eff_w-1:0] eff_base_o, plc_addr_i, base, old;
    logic [15:0] v [5];
    logic [15:0] ofs [5] = '{ofs_plc_register_class, ofs_base_number_high, ofs_base_number_low,
                             ofs_unit_address_bias, ofs_bias_apply_select};
    int err_count = 0, cmp_count = 0, seed = 20386;
    always #5 clock_i = ~clock_i;
    plc_link_address_config u_plc_link_address_config (.clock_i(clock_i), .rstn_i(rstn_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
        .reg_err_o(reg_err_o), .run_i(run_i), .addr_switch_i(addr_switch_i),
        .live_mode_i(live_mode_i), .comm_cycle_i(comm_cycle_i), .plc_addr_i(plc_addr_i),
        .eff_base_o(eff_base_o), .active_class_o(active_class_o),
        .status_hit_o(status_hit_o), .status_index_o(status_index_o),
        .live_word_o(live_word_o));
    plc_model u_plc_model (.clock_i(clock_i), .plc_addr_o(plc_addr_i), .cycle_o(comm_cycle_i));
    // ========================================================
    // helpers
    function automatic logic [eff_w-1:0] exp_base(input logic [15:0] h, l, b, s,
                                                 input logic [switch_w-1:0] sw);
        exp_base = {h[3:0], l};
        if (s === sel_bias_enabled)
            exp_base = exp_base + eff_w'(sw) * eff_w'(b);
    endfunction : exp_base
    // one strobe, ack and answer looked at in the single cycle they stand
    task automatic rw(input logic wr, input logic [15:0] a, d, input logic e,
                      input logic [15:0] xr);
        @(negedge clock_i);
        reg_wr_i = wr;
        reg_rd_i = !wr;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clock_i);
        reg_wr_i = 0;
        reg_rd_i = 0;
        `CHK(reg_ack_o, 1'b1)
        `CHK(reg_err_o, e)
        if (!wr)
            `CHK(reg_rdata_o, xr)
    endtask : rw
    task automatic probe(input logic [eff_w-1:0] a, input logic h, input logic [2:0] i);
        u_plc_model.access(a);
        @(negedge clock_i);
        `CHK(status_hit_o, h)
        if (h)
            `CHK(status_index_o, i)
    endtask : probe
    task automatic tally_and_finish;
        $display("counts: compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    // ========================================================
    // main sequence
    initial
    begin
        repeat (3) @(negedge clock_i);
        rstn_i = 1;
        foreach (ofs[k])
            rw(0, ofs[k], 0, 0, cfg_reset[79-16*k -: 16]);
        `CHK(eff_base_o, eff_w'(1000))
        $display("test reset done");
        rw(0, 16'h800E, 0, 1, 16'h0000);
        rw(1, 16'h8000, 16'h1234, 1, 0);
        rw(1, ofs[0], 16'h001E, 1, 0);
        rw(1, ofs[1], 16'h0010, 1, 0);
        rw(1, ofs[4], 16'h0002, 1, 0);
        rw(0, ofs[0], 0, 0, 16'h0000);
        rw(0, ofs[1], 0, 0, 16'h0000);
        rw(0, ofs[4], 0, 0, 16'h0001);
        rw(1, ofs[0], 16'h001D, 0, 0);
        rw(0, ofs[0], 0, 0, 16'h001D);
        $display("test refusal done");
        for (int c = 0; c < 4; c++)
        begin
            v[0] = 16'(c);
            v[1] = 16'($random(seed)) & 16'h000F;
            v[2] = 16'($random(seed));
            v[3] = 16'($random(seed));
            v[4] = (c == 3) ? 16'h0001 : 16'h0000;
            addr_switch_i = switch_w'($random(seed));
            if (c == 0)
            begin
                v[1] = 16'h000F;
                v[2] = 16'hFFFF;
                v[3] = 16'hFFFF;
                addr_switch_i = '1;
            end
            // write then read in back-to-back cycles; the writes below replace this value
            @(negedge clock_i);
            reg_wr_i = 1;
            reg_addr_i = ofs[3];
            reg_wdata_i = ~v[3];
            @(negedge clock_i);
            `CHK(reg_ack_o, 1'b1)
            reg_wr_i = 0;
            reg_rd_i = 1;
            @(negedge clock_i);
            reg_rd_i = 0;
            `CHK(reg_ack_o, 1'b1)
            `CHK(reg_rdata_o, ~v[3])
            // the switch is a live input, so the base is taken only after it has settled
            old = eff_base_o;
            foreach (ofs[k])
                rw(1, ofs[k], v[k], 0, 0);
            foreach (ofs[k])
                rw(0, ofs[k], 0, 0, v[k]);
            `CHK(eff_base_o, old)
            @(negedge clock_i);
            run_i = 0;
            @(negedge clock_i);
            run_i = 1;
            repeat (2) @(negedge clock_i);
            base = exp_base(v[1], v[2], v[3], v[4], addr_switch_i);
            `CHK(eff_base_o, base)
            `CHK(active_class_o, v[0])
            if (base > 0)
                probe(base - 1, 0, 0);
            probe(base, 1, 0);
            probe(base + 7, 1, 7);
            probe(base + 8, 0, 0);
        end
        $display("test activation done");
        u_plc_model.pulse(3);
        `CHK(live_word_o, live_one)
        live_mode_i = 1;
        u_plc_model.pulse(4);
        `CHK(live_word_o, 16'h0005)
        u_plc_model.pulse(29995);
        `CHK(live_word_o, live_count_wrap)
        u_plc_model.pulse(1);
        `CHK(live_word_o, 16'h0000)
        $display("test liveness done");
        tally_and_finish();
    end
endmodule : tb_top
